// >>> core/fdc_cmd_pkg.sv
// constants, types and register map of the floppy command sequencer
package fdc_cmd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] data_port_addr = 8'h00;
  localparam logic [7:0] main_status_addr = 8'h04;
  localparam logic [7:0] int_status_addr = 8'h08;
  localparam logic [7:0] int_mask_addr = 8'h0c;
  localparam logic [7:0] position_addr = 8'h10;

  // ----------------------------------------------------------------
  // interrupt event bits
  // ----------------------------------------------------------------
  localparam int ev_width = 3;
  localparam int ev_taken_bit = 0;
  localparam int ev_done_bit = 1;
  localparam int ev_invalid_bit = 2;
  localparam logic [ev_width-1:0] mask_reset = 3'h0;

  // ----------------------------------------------------------------
  // main status bits
  // ----------------------------------------------------------------
  localparam int ms_busy_bit = 0;
  localparam int ms_exec_bit = 1;
  localparam int ms_result_bit = 2;

  // ----------------------------------------------------------------
  // opcode patterns and drive byte layout
  // ----------------------------------------------------------------
  localparam logic [4:0] op_read_deleted = 5'h0c;
  localparam logic [5:0] op_read_track = 6'h02;
  localparam logic [5:0] op_read_id = 6'h0a;
  localparam logic [5:0] op_write_data = 6'h05;
  localparam int op_multi_bit = 7;
  localparam int op_dens_bit = 6;
  localparam int op_skip_bit = 5;
  localparam int drv_head_bit = 2;

  // ----------------------------------------------------------------
  // byte counts and fixed values
  // ----------------------------------------------------------------
  localparam logic [3:0] sector_cmd_bytes = 4'h9;
  localparam logic [3:0] read_id_cmd_bytes = 4'h2;
  localparam logic [3:0] invalid_cmd_bytes = 4'h1;
  localparam logic [3:0] sector_last_result = 4'h6;
  localparam logic [3:0] invalid_last_result = 4'h0;
  localparam logic [7:0] invalid_status0 = 8'h80;
  localparam logic [7:0] first_record = 8'h01;
  localparam logic [7:0] second_head = 8'h01;

  typedef enum logic [1:0] {
    phase_command, phase_execute, phase_result
  } phase_t;

  typedef enum logic [2:0] {
    cmd_invalid, cmd_read_deleted, cmd_read_track, cmd_read_id, cmd_write_data
  } cmd_kind_t;

endpackage

// >>> core/fdc_opcode_decode.sv
// opcode decoder: command kind and command byte count
`timescale 1ns/100ps
module fdc_opcode_decode
  import fdc_cmd_pkg::*;
(
  input wire logic [7:0] opcode_in,
  output cmd_kind_t kind_out,
  output logic [3:0] cmd_bytes_out
);

  // ----------------------------------------------------------------
  // pattern match
  // ----------------------------------------------------------------
  always_comb begin
    kind_out = cmd_invalid;
    cmd_bytes_out = invalid_cmd_bytes;
    if (opcode_in[4:0] == op_read_deleted) begin
      kind_out = cmd_read_deleted;
      cmd_bytes_out = sector_cmd_bytes;
    end else if (!opcode_in[op_multi_bit] && opcode_in[5:0] == op_read_track) begin
      kind_out = cmd_read_track;
      cmd_bytes_out = sector_cmd_bytes;
    end else if (!opcode_in[op_multi_bit] && opcode_in[5:0] == op_read_id) begin
      kind_out = cmd_read_id;
      cmd_bytes_out = read_id_cmd_bytes;
    end else if (opcode_in[5:0] == op_write_data) begin
      kind_out = cmd_write_data;
      cmd_bytes_out = sector_cmd_bytes;
    end
  end

endmodule

// >>> core/fdc_cmd_seq.sv
// command, execution and result sequencer for four floppy commands
//
// What this block does
// - drive byte then seven sector parameters
// - seven result bytes: status then position; one status byte for an invalid opcode
// - decode read deleted data opcode
// - decode read track, index to final sector
// - decode read id, two command bytes
// - capture first good id field
// - read id returns status and captured id
// - decode write data, system to drive
// - command, execute, result phases in order
// - skip deleted sectors when bypass set
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module fdc_cmd_seq
  import fdc_cmd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  output logic irq_out,
  // disk engine side
  input wire logic sector_mark_in,
  input wire logic sector_deleted_in,
  input wire logic sector_end_in,
  input wire logic id_valid_in,
  input wire logic [7:0] id_cyl_in,
  input wire logic [7:0] id_head_in,
  input wire logic [7:0] id_record_in,
  input wire logic [7:0] id_size_in,
  input wire logic fault_in,
  input wire logic [7:0] status0_in,
  input wire logic [7:0] status1_in,
  input wire logic [7:0] status2_in,
  output logic exec_start_out,
  output logic exec_busy_out,
  output cmd_kind_t cmd_kind_out,
  output logic multi_track_out,
  output logic double_density_mode_out,
  output logic head_select_out,
  output logic [1:0] drive_select_out,
  output logic [7:0] cyl_out,
  output logic [7:0] head_out,
  output logic [7:0] record_out,
  output logic [7:0] size_out,
  output logic [7:0] final_sector_number_out,
  output logic [7:0] gap_length_out,
  output logic [7:0] custom_data_length_out,
  output logic xfer_sector_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    cmd_kind_t kind;
    logic [3:0] idx;
    logic [3:0] need;
    logic multi;
    logic dens;
    logic skip;
    logic side;
    logic [1:0] drv;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] rec;
    logic [7:0] size;
    logic [7:0] last_sec;
    logic [7:0] gap;
    logic [7:0] dlen;
    logic [7:0] stat0;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic xfer;
    logic exe;
    logic strt;
    logic busy;
    logic [ev_width-1:0] ist;
    logic [ev_width-1:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  localparam state_t reset_state = '{
    phase: phase_command,
    kind: cmd_invalid,
    imask: mask_reset,
    default: '0
  };

  state_t s;
  state_t next_s;
  cmd_kind_t dec_kind;
  logic [3:0] dec_bytes;

  // ----------------------------------------------------------------
  // opcode decoder
  // ----------------------------------------------------------------
  fdc_opcode_decode u_decode (
    .opcode_in(pwdata_in[7:0]),
    .kind_out(dec_kind),
    .cmd_bytes_out(dec_bytes)
  );

  // ----------------------------------------------------------------
  // result byte selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] result_byte(input state_t st);
    logic [7:0] b;
    b = 8'h00;
    unique case (st.idx)
      4'h0: b = st.stat0;
      4'h1: b = st.stat1;
      4'h2: b = st.stat2;
      4'h3: b = st.cyl;
      4'h4: b = st.head;
      4'h5: b = st.rec;
      4'h6: b = st.size;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic access;
    logic commit;
    logic wr_data;
    logic rd_data;
    logic finish;
    logic [ev_width-1:0] ev;
    logic [ev_width-1:0] clr;
    logic [3:0] last;
    access = 1'b0;
    commit = 1'b0;
    wr_data = 1'b0;
    rd_data = 1'b0;
    finish = 1'b0;
    ev = '0;
    clr = '0;
    last = sector_last_result;
    next_s = s;
    next_s.strt = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    access = psel_in && penable_in && !s.pready;
    commit = psel_in && penable_in && s.pready;
    wr_data = commit && pwrite_in && paddr_in == data_port_addr;
    rd_data = commit && !pwrite_in && paddr_in == data_port_addr;
    if (s.kind == cmd_invalid) begin
      last = invalid_last_result;
    end

    // bus read value and wait state
    if (access) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr_in)
        data_port_addr: begin
          if (s.phase == phase_result) begin
            next_s.prdata[7:0] = result_byte(s);
          end
        end
        main_status_addr: begin
          next_s.prdata[ms_busy_bit] = s.busy;
          next_s.prdata[ms_exec_bit] = s.phase == phase_execute;
          next_s.prdata[ms_result_bit] = s.phase == phase_result;
        end
        int_status_addr: next_s.prdata[ev_width-1:0] = s.ist;
        int_mask_addr: next_s.prdata[ev_width-1:0] = s.imask;
        position_addr: next_s.prdata = {s.size, s.rec, s.head, s.cyl};
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // register writes
    if (commit && pwrite_in && paddr_in == int_status_addr) begin
      clr = pwdata_in[ev_width-1:0];
    end
    if (commit && pwrite_in && paddr_in == int_mask_addr) begin
      next_s.imask = pwdata_in[ev_width-1:0];
    end

    unique case (s.phase)
      phase_command: begin
        if (wr_data) begin
          next_s.idx = s.idx + 4'h1;
          next_s.busy = 1'b1;
          unique case (s.idx)
            4'h0: begin
              next_s.kind = dec_kind;
              next_s.need = dec_bytes;
              next_s.dens = pwdata_in[op_dens_bit];
              next_s.multi = 1'b0;
              next_s.skip = 1'b0;
              if (dec_kind == cmd_read_deleted || dec_kind == cmd_write_data) begin
                next_s.multi = pwdata_in[op_multi_bit];
              end
              if (dec_kind == cmd_read_deleted) begin
                next_s.skip = pwdata_in[op_skip_bit];
              end
              if (dec_kind == cmd_invalid) begin
                next_s.phase = phase_result;
                next_s.idx = 4'h0;
                next_s.stat0 = invalid_status0;
                ev[ev_invalid_bit] = 1'b1;
              end
            end
            4'h1: begin
              next_s.side = pwdata_in[drv_head_bit];
              next_s.drv = pwdata_in[1:0];
            end
            4'h2: next_s.cyl = pwdata_in[7:0];
            4'h3: next_s.head = pwdata_in[7:0];
            4'h4: next_s.rec = pwdata_in[7:0];
            4'h5: next_s.size = pwdata_in[7:0];
            4'h6: next_s.last_sec = pwdata_in[7:0];
            4'h7: next_s.gap = pwdata_in[7:0];
            4'h8: next_s.dlen = pwdata_in[7:0];
            default: next_s.idx = s.idx;
          endcase
          if (s.idx != 4'h0 && s.idx + 4'h1 == s.need) begin
            next_s.phase = phase_execute;
            next_s.idx = 4'h0;
            next_s.strt = 1'b1;
            next_s.xfer = 1'b0;
            ev[ev_taken_bit] = 1'b1;
            if (s.kind == cmd_read_track) begin
              next_s.rec = first_record;
            end
          end
        end
      end

      phase_execute: begin
        if (fault_in) begin
          finish = 1'b1;
        end else if (s.kind == cmd_read_id) begin
          if (id_valid_in) begin
            next_s.cyl = id_cyl_in;
            next_s.head = id_head_in;
            next_s.rec = id_record_in;
            next_s.size = id_size_in;
            finish = 1'b1;
          end
        end else begin
          if (sector_mark_in) begin
            next_s.xfer = !(s.skip && sector_deleted_in);
          end
          if (sector_end_in) begin
            next_s.xfer = 1'b0;
            if (s.rec == s.last_sec) begin
              if (s.multi && !s.side) begin
                next_s.side = 1'b1;
                next_s.head = second_head;
                next_s.rec = first_record;
              end else begin
                finish = 1'b1;
              end
            end else begin
              next_s.rec = s.rec + 8'h01;
            end
          end
        end
        if (finish) begin
          next_s.phase = phase_result;
          next_s.idx = 4'h0;
          next_s.xfer = 1'b0;
          next_s.stat0 = status0_in;
          next_s.stat1 = status1_in;
          next_s.stat2 = status2_in;
          ev[ev_done_bit] = 1'b1;
        end
      end

      phase_result: begin
        if (rd_data) begin
          if (s.idx == last) begin
            next_s.phase = phase_command;
            next_s.idx = 4'h0;
            next_s.busy = 1'b0;
          end else begin
            next_s.idx = s.idx + 4'h1;
          end
        end
      end

      default: next_s.phase = phase_command;
    endcase

    // sticky events, a new event beats the clear
    next_s.ist = (s.ist & ~clr) | ev;
    next_s.irq = |(next_s.ist & next_s.imask);
    // execution flag kept in a flop of its own
    next_s.exe = next_s.phase == phase_execute;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s <= reset_state;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from state
  // ----------------------------------------------------------------
  assign pready_out = s.pready;
  assign prdata_out = s.prdata;
  assign pslverr_out = s.pslverr;
  assign irq_out = s.irq;
  assign exec_start_out = s.strt;
  assign exec_busy_out = s.exe;
  assign cmd_kind_out = s.kind;
  assign multi_track_out = s.multi;
  assign double_density_mode_out = s.dens;
  assign head_select_out = s.side;
  assign drive_select_out = s.drv;
  assign cyl_out = s.cyl;
  assign head_out = s.head;
  assign record_out = s.rec;
  assign size_out = s.size;
  assign final_sector_number_out = s.last_sec;
  assign gap_length_out = s.gap;
  assign custom_data_length_out = s.dlen;
  assign xfer_sector_out = s.xfer;

endmodule

// >>> tb/fdc_cmd_seq_props.sv
// assertions on the ports of the floppy command sequencer
`timescale 1ns/100ps
module fdc_cmd_seq_props
  import fdc_cmd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pready_out,
  input wire logic exec_start_out,
  input wire logic exec_busy_out,
  input cmd_kind_t cmd_kind_out,
  input wire logic multi_track_out,
  input wire logic head_select_out,
  input wire logic [7:0] head_out,
  input wire logic [7:0] record_out,
  input wire logic [7:0] cyl_out,
  input wire logic [7:0] final_sector_number_out,
  input wire logic sector_mark_in,
  input wire logic sector_deleted_in,
  input wire logic sector_end_in,
  input wire logic id_valid_in,
  input wire logic [7:0] id_cyl_in,
  input wire logic [7:0] id_record_in,
  input wire logic fault_in,
  input wire logic xfer_sector_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // steps of an execution
  // ----------------------------------------------------------------
  sequence s_end;
    exec_busy_out && sector_end_in && !fault_in && cmd_kind_out != cmd_read_id;
  endsequence
  sequence s_start;
    exec_start_out && cmd_kind_out == cmd_read_track;
  endsequence
  sequence s_id;
    exec_busy_out && cmd_kind_out == cmd_read_id && id_valid_in && !fault_in;
  endsequence

  property p_ready_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_start_busy;
    exec_start_out |-> ##[0:1] exec_busy_out ##1 !exec_start_out;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_fault;
    exec_busy_out && fault_in |=> !exec_busy_out;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not end execution");
  property p_id_capture;
    s_id |=> !exec_busy_out && cyl_out == $past(id_cyl_in) && record_out == $past(id_record_in);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id field not kept");
  property p_advance;
    s_end ##0 (record_out != final_sector_number_out) |=>
      exec_busy_out && record_out == $past(record_out) + 8'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("record did not advance");
  property p_head_switch;
    s_end ##0 (record_out == final_sector_number_out && multi_track_out && !head_select_out)
      |=> exec_busy_out && head_select_out && head_out == 8'h01 && record_out == 8'h01;
  endproperty
  a_head_switch: assert property (p_head_switch) else $error("no second head");
  property p_stop;
    s_end ##0 (record_out == final_sector_number_out && !(multi_track_out && !head_select_out))
      |=> !exec_busy_out;
  endproperty
  a_stop: assert property (p_stop) else $error("did not stop at final sector");
  property p_track_first;
    s_start |-> ##[0:2] record_out == 8'h01;
  endproperty
  a_track_first: assert property (p_track_first) else $error("track not from first");
  property p_xfer_on;
    exec_busy_out && sector_mark_in && !sector_deleted_in && !sector_end_in && !fault_in
      |=> xfer_sector_out;
  endproperty
  a_xfer_on: assert property (p_xfer_on) else $error("sector not moved");
  property p_xfer_off;
    xfer_sector_out && sector_end_in |=> !xfer_sector_out;
  endproperty
  a_xfer_off: assert property (p_xfer_off) else $error("transfer past sector end");
endmodule

bind fdc_cmd_seq fdc_cmd_seq_props i_props (.*);

// >>> tb/disk_engine_model.sv
// disk engine stand-in that answers the sequencer's execution phase
`timescale 1ns/100ps
module disk_engine_model
  import fdc_cmd_pkg::*;
#(
  parameter logic [7:0] status0_val = 8'h41,
  parameter logic [7:0] status1_val = 8'h02,
  parameter logic [7:0] status2_val = 8'h10,
  parameter logic [31:0] id_val = 32'h0207012a
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic busy_in,
  input cmd_kind_t kind_in,
  input wire logic [3:0] gap_in,
  input wire logic deleted_in,
  output logic mark_out,
  output logic deleted_out,
  output logic end_out,
  output logic id_valid_out,
  output logic [31:0] id_out,
  output logic [7:0] status0_out,
  output logic [7:0] status1_out,
  output logic [7:0] status2_out
);
  logic [4:0] cnt = 5'h00;
  logic act;
  logic is_id;

  // ----------------------------------------------------------------
  // sector timing, gap_in sets prompt or slow answers
  // ----------------------------------------------------------------
  assign act = (busy_in === 1'b1);
  assign is_id = (kind_in == cmd_read_id);
  always_ff @(posedge clk_in) begin
    if (rst_in || !act || end_out) cnt <= 5'h00;
    else cnt <= cnt + 5'h01;
  end
  // one mark then one end per sector
  assign mark_out = act && !is_id && cnt == {1'b0, gap_in};
  assign deleted_out = mark_out && deleted_in;
  assign end_out = act && !is_id && cnt == {gap_in, 1'b0};
  // one good id field, invalid outside its pulse
  assign id_valid_out = act && is_id && cnt == {1'b0, gap_in};
  assign id_out = id_valid_out ? id_val : ~id_val;
  assign status0_out = act ? status0_val : ~status0_val;
  assign status1_out = act ? status1_val : ~status1_val;
  assign status2_out = act ? status2_val : ~status2_val;
endmodule

// >>> tb/test_floppy_read_write_cmd_decoder.sv
// self-checking testbench of the floppy command sequencer
`timescale 1ns/100ps
module test_floppy_read_write_cmd_decoder;
  import fdc_cmd_pkg::*;
  typedef logic [7:0] byte9_t [9];
  localparam logic [7:0] s0 = 8'h41, s1 = 8'h02, s2 = 8'h10;
  logic mclk_in = 1'b0, rst_in = 1'b1, fault_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, par_seen;
  logic pready_out, pslverr_out, irq_out, exec_start_out, exec_busy_out, xfer_sector_out;
  logic multi_track_out, double_density_mode_out, head_select_out;
  logic sector_mark_in, sector_deleted_in, sector_end_in, id_valid_in;
  logic [1:0] drive_select_out, drv_seen;
  logic [7:0] id_cyl_in, id_head_in, id_record_in, id_size_in, status0_in, status1_in, status2_in;
  logic [7:0] cyl_out, head_out, record_out, size_out, final_sector_number_out;
  logic [7:0] gap_length_out, custom_data_length_out;
  cmd_kind_t cmd_kind_out, kind_seen;
  logic [3:0] gap = 4'h1;
  logic del = 1'b0, arm = 1'b0, err, hs_seen, dd_seen;
  int n_errors = 0, n_tests = 0, n_xfer = 0;

  fdc_cmd_seq i_dut (.*);
  disk_engine_model i_disk (.clk_in(mclk_in), .rst_in(rst_in), .busy_in(exec_busy_out),
    .kind_in(cmd_kind_out), .gap_in(gap), .deleted_in(del), .mark_out(sector_mark_in),
    .deleted_out(sector_deleted_in), .end_out(sector_end_in), .id_valid_out(id_valid_in),
    .id_out({id_size_in, id_record_in, id_head_in, id_cyl_in}), .status0_out(status0_in),
    .status1_out(status1_in), .status2_out(status2_in));

  always #5 mclk_in = ~mclk_in;
  // decode capture, transfer count and fault pulses
  always @(posedge mclk_in) begin
    if (xfer_sector_out) n_xfer <= n_xfer + 1;
    if (exec_start_out) begin
      kind_seen <= cmd_kind_out;
      {dd_seen, hs_seen, drv_seen} <= {double_density_mode_out, head_select_out, drive_select_out};
      par_seen <= {size_out, final_sector_number_out, gap_length_out, custom_data_length_out};
    end
    fault_in <= arm && exec_busy_out && !fault_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // command bytes, wait for result phase, read and compare results
  task automatic run(input byte9_t c, input int nc, input byte9_t r, input int nr);
    n_xfer = 0;
    for (int i = 0; i < nc; i++) apb(1'b1, data_port_addr, {24'h0, c[i]});
    do begin
      apb(1'b0, main_status_addr, 32'h0);
    end while (rd[ms_result_bit] !== 1'b1);
    for (int i = 0; i < nr; i++) begin
      apb(1'b0, data_port_addr, 32'h0);
      chk("result byte", {24'h0, r[i]}, rd);
    end
    apb(1'b0, main_status_addr, 32'h0);
    chk("idle status", 32'h0, rd);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #300000;
    n_errors++;
    finish_test;
  end

  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    apb(1'b0, main_status_addr, 32'h0);
    chk("main status", 32'h0, rd);
    apb(1'b0, int_mask_addr, 32'h0);
    chk("mask", {29'h0, mask_reset}, rd);
    apb(1'b0, data_port_addr, 32'h0);
    chk("data idle", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, int_mask_addr, 32'h7);
    $display("registers test done");
    del <= 1'b1;
    run('{8'h6c, 8'h05, 8'h03, 8'h01, 8'h02, 8'h02, 8'h04, 8'h1b, 8'hff}, 9,
      '{s0, s1, s2, 8'h03, 8'h01, 8'h04, 8'h02, 8'h00, 8'h00}, 7);
    chk("decode", {cmd_read_deleted, 4'hd}, {kind_seen, dd_seen, hs_seen, drv_seen});
    chk("params", 32'h02041bff, par_seen);
    chk("skipped", 32'h0, n_xfer);
    chk("irq", 32'h1, {31'h0, irq_out});
    apb(1'b1, int_mask_addr, 32'h0);
    apb(1'b0, int_status_addr, 32'h0);
    chk("int status", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    apb(1'b1, int_status_addr, 32'h7);
    apb(1'b1, int_mask_addr, 32'h7);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    $display("read deleted test done");
    del <= 1'b0;
    gap <= 4'h6;
    run('{8'hc5, 8'h00, 8'h07, 8'h00, 8'h01, 8'h02, 8'h02, 8'h1b, 8'hff}, 9,
      '{s0, s1, s2, 8'h07, 8'h01, 8'h02, 8'h02, 8'h00, 8'h00}, 7);
    chk("decode", {cmd_write_data, 4'h8}, {kind_seen, dd_seen, hs_seen, drv_seen});
    chk("moved", 32'h1, {31'h0, n_xfer > 0});
    $display("write data test done");
    gap <= 4'h1;
    run('{8'h42, 8'h00, 8'h09, 8'h00, 8'h05, 8'h02, 8'h03, 8'h1b, 8'hff}, 9,
      '{s0, s1, s2, 8'h09, 8'h00, 8'h03, 8'h02, 8'h00, 8'h00}, 7);
    chk("decode", {cmd_read_track, 4'h8}, {kind_seen, dd_seen, hs_seen, drv_seen});
    $display("read track test done");
    run('{8'h4a, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2,
      '{s0, s1, s2, 8'h2a, 8'h01, 8'h07, 8'h02, 8'h00, 8'h00}, 7);
    chk("decode", {cmd_read_id, 4'h9}, {kind_seen, dd_seen, hs_seen, drv_seen});
    apb(1'b0, position_addr, 32'h0);
    chk("position", 32'h0207012a, rd);
    $display("read id test done");
    run('{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1,
      '{invalid_status0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    apb(1'b0, int_status_addr, 32'h0);
    chk("invalid event", 32'h1, {31'h0, rd[ev_invalid_bit]});
    apb(1'b1, int_status_addr, 32'h7);
    $display("invalid test done");
    gap <= 4'h6;
    arm <= 1'b1;
    run('{8'h45, 8'h02, 8'h05, 8'h00, 8'h03, 8'h01, 8'h08, 8'h1b, 8'hff}, 9,
      '{s0, s1, s2, 8'h05, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00}, 7);
    arm <= 1'b0;
    $display("fault test done");
    finish_test;
  end
endmodule
